// *** pkg/bscr_pkg.sv ***
// Package for the buck set point and configuration register bank.
// Assumes a 100 MHz core clock and an APB slave with 32-bit data.
package bscr_pkg;

	// ==========================================================
	// Register map (printed offsets are indices, not byte addresses)
	localparam logic [7:0] BSCR_IDX_NORMAL = 8'h20;
	localparam logic [7:0] BSCR_IDX_STANDBY = 8'h21;
	localparam logic [7:0] BSCR_IDX_SLEEP = 8'h22;
	localparam logic [7:0] BSCR_IDX_MODE = 8'h23;
	localparam logic [7:0] BSCR_IDX_CONF = 8'h24;
	// Operating-mode status register, added beside the documented ones
	localparam logic [7:0] BSCR_IDX_STATUS = 8'h25;
	localparam int BSCR_ADDR_W = 10;

	// ==========================================================
	// Reset values
	localparam logic [7:0] BSCR_RST_SETPOINT = 8'h00;
	localparam logic [7:0] BSCR_RST_MODE = 8'h00;
	localparam logic [7:0] BSCR_RST_CONF = 8'h00;

	// ==========================================================
	// Field layout
	localparam int BSCR_CODE_W = 6;
	localparam int BSCR_CODE_LSB = 0;
	localparam int BSCR_SWMODE_W = 4;
	localparam int BSCR_SWMODE_LSB = 0;
	localparam int BSCR_KEEPALIVE_BIT = 5;
	localparam int BSCR_ILIM_BIT = 0;
	localparam int BSCR_FREQ_LSB = 2;
	localparam int BSCR_PHASE_LSB = 4;
	localparam int BSCR_SPEED_LSB = 6;
	localparam int BSCR_SEL_W = 2;

	// Writable bit masks; all others read as zero
	localparam logic [7:0] BSCR_MASK_CODE = 8'h3f;
	localparam logic [7:0] BSCR_MASK_MODE = 8'h2f;
	localparam logic [7:0] BSCR_MASK_CONF = 8'hfd;

	// ==========================================================
	// Voltage coding in millivolts
	localparam int BSCR_VMIN_MV = 300;
	localparam int BSCR_VSTEP_MV = 25;
	localparam int BSCR_MV_W = 11;

	// ==========================================================
	// Timing: step periods in microseconds, clock in MHz
	localparam int BSCR_CLK_MHZ = 100;
	localparam int BSCR_STEP0_US = 2;
	localparam int BSCR_STEP1_US = 4;
	localparam int BSCR_STEP2_US = 8;
	localparam int BSCR_STEP3_US = 16;
	localparam int BSCR_STEP0_CYC = BSCR_STEP0_US * BSCR_CLK_MHZ;
	localparam int BSCR_STEP1_CYC = BSCR_STEP1_US * BSCR_CLK_MHZ;
	localparam int BSCR_STEP2_CYC = BSCR_STEP2_US * BSCR_CLK_MHZ;
	localparam int BSCR_STEP3_CYC = BSCR_STEP3_US * BSCR_CLK_MHZ;
	localparam int BSCR_CNT_W = 11;

	// Frequency codes in kHz; reserved code gives zero
	localparam logic [12:0] BSCR_FREQ0_KHZ = 13'h03e8;
	localparam logic [12:0] BSCR_FREQ1_KHZ = 13'h07d0;
	localparam logic [12:0] BSCR_FREQ2_KHZ = 13'h0fa0;
	localparam logic [12:0] BSCR_FREQ_RSVD = 13'h0000;
	localparam logic [8:0] BSCR_PHASE_STEP_DEG = 9'h05a;

	// Operating modes
	typedef enum logic [1:0] {
		BSCR_OP_NORMAL,
		BSCR_OP_STANDBY,
		BSCR_OP_SLEEP
	} bscr_op_t;

	// Stepper states
	typedef enum logic [1:0] {
		BSCR_ST_IDLE,
		BSCR_ST_WAIT,
		BSCR_ST_STEP
	} bscr_step_t;

endpackage : bscr_pkg

// *** rtl/bscr_regs.sv ***
// Buck set point and configuration register bank with APB slave.
// Assumes APB master on the core clock; operating mode from the sequencer.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps

module bscr_regs
	import bscr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [BSCR_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Operating mode from the power sequencer
	input wire logic i_mode_standby,
	input wire logic i_mode_sleep,
	// Regulator controls
	output logic [BSCR_CODE_W-1:0] o_target_code,
	output logic [BSCR_CODE_W-1:0] o_applied_code,
	output logic [BSCR_MV_W-1:0] o_applied_mv,
	output logic o_stepping,
	output logic o_reg_enable,
	output logic o_pfm_force,
	output logic [BSCR_SWMODE_W-1:0] o_switch_mode_field,
	output logic o_current_limit_low_sel,
	output logic [12:0] o_switch_freq_khz,
	output logic o_freq_reserved,
	output logic [8:0] o_clock_phase_deg,
	output logic [1:0] o_voltage_step_speed_sel
);

	// ==========================================================
	// Register storage
	logic [7:0] normal_setpoint_q;
	logic [7:0] standby_setpoint_q;
	logic [7:0] sleep_setpoint_q;
	logic [7:0] switching_mode_select_q;
	logic [7:0] regulator_config_q;

	// ==========================================================
	// Functions
	// Byte address of a register index
	function automatic logic [BSCR_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction : reg_addr

	// Millivolts for a set point code
	function automatic logic [BSCR_MV_W-1:0] code_to_mv(input logic [5:0] code);
		code_to_mv = BSCR_MV_W'(BSCR_VMIN_MV) +
			BSCR_MV_W'(code) * BSCR_MV_W'(BSCR_VSTEP_MV);
	endfunction : code_to_mv

	// Masked write of the low byte
	function automatic logic [7:0] wr_byte(input logic [7:0] old,
		input logic [7:0] data, input logic [7:0] mask);
		wr_byte = (old & ~mask) | (data & mask);
	endfunction : wr_byte

	// ==========================================================
	// APB decode
	logic access_w;
	logic wr_w;
	logic lane0_w;
	logic aligned_w;
	logic hit_normal_w;
	logic hit_standby_w;
	logic hit_sleep_w;
	logic hit_mode_w;
	logic hit_conf_w;
	logic hit_status_w;
	logic hit_any_w;
	logic [7:0] rd_byte_w;
	logic [7:0] status_w;

	// Access phase; zero wait states, pready is high for the one access cycle only
	assign access_w = i_psel && i_penable;
	assign wr_w = access_w && i_pwrite;
	assign lane0_w = i_pstrb[0];
	assign aligned_w = (i_paddr[1:0] == 2'b00);
	assign hit_normal_w = aligned_w && (i_paddr == reg_addr(BSCR_IDX_NORMAL));
	assign hit_standby_w = aligned_w && (i_paddr == reg_addr(BSCR_IDX_STANDBY));
	assign hit_sleep_w = aligned_w && (i_paddr == reg_addr(BSCR_IDX_SLEEP));
	assign hit_mode_w = aligned_w && (i_paddr == reg_addr(BSCR_IDX_MODE));
	assign hit_conf_w = aligned_w && (i_paddr == reg_addr(BSCR_IDX_CONF));
	assign hit_status_w = aligned_w && (i_paddr == reg_addr(BSCR_IDX_STATUS));
	assign hit_any_w = hit_normal_w || hit_standby_w || hit_sleep_w ||
		hit_mode_w || hit_conf_w || hit_status_w;

	// ==========================================================
	// Operating mode and applied set point
	bscr_op_t op_w;
	logic [BSCR_CODE_W-1:0] sel_code_w;
	logic sleep_off_w;

	// Sleep wins over standby if the sequencer asserts both
	assign op_w = i_mode_sleep ? BSCR_OP_SLEEP :
		(i_mode_standby ? BSCR_OP_STANDBY : BSCR_OP_NORMAL);
	assign sel_code_w = (op_w == BSCR_OP_SLEEP) ? sleep_setpoint_q[5:0] :
		(op_w == BSCR_OP_STANDBY) ? standby_setpoint_q[5:0] :
		normal_setpoint_q[5:0];
	// Regulator off in sleep unless the keepalive bit is set
	assign sleep_off_w = (op_w == BSCR_OP_SLEEP) &&
		!switching_mode_select_q[BSCR_KEEPALIVE_BIT];

	// Status: op mode in 1:0, stepping in bit 2, regulator on in bit 3
	assign status_w = {4'h0, o_reg_enable, o_stepping, op_w};

	// Read mux; unmapped reads return zero
	assign rd_byte_w = hit_normal_w ? normal_setpoint_q :
		hit_standby_w ? standby_setpoint_q :
		hit_sleep_w ? sleep_setpoint_q :
		hit_mode_w ? switching_mode_select_q :
		hit_conf_w ? regulator_config_q :
		hit_status_w ? status_w : 8'h00;

	// ==========================================================
	// Register writes; unused bits masked to stay zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			normal_setpoint_q <= BSCR_RST_SETPOINT;
			standby_setpoint_q <= BSCR_RST_SETPOINT;
			sleep_setpoint_q <= BSCR_RST_SETPOINT;
			switching_mode_select_q <= BSCR_RST_MODE;
			regulator_config_q <= BSCR_RST_CONF;
		end else if (wr_w && lane0_w) begin
			if (hit_normal_w)
				normal_setpoint_q <= wr_byte(normal_setpoint_q, i_pwdata[7:0],
					BSCR_MASK_CODE);
			if (hit_standby_w)
				standby_setpoint_q <= wr_byte(standby_setpoint_q, i_pwdata[7:0],
					BSCR_MASK_CODE);
			if (hit_sleep_w)
				sleep_setpoint_q <= wr_byte(sleep_setpoint_q, i_pwdata[7:0],
					BSCR_MASK_CODE);
			if (hit_mode_w)
				switching_mode_select_q <= wr_byte(switching_mode_select_q,
					i_pwdata[7:0], BSCR_MASK_MODE);
			if (hit_conf_w)
				regulator_config_q <= wr_byte(regulator_config_q, i_pwdata[7:0],
					BSCR_MASK_CONF);
		end
	end

	// ==========================================================
	// APB answer: registered, data valid with pready in access phase
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= '0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !hit_any_w;
			o_prdata <= (i_psel && !i_penable && !i_pwrite) ? {24'h0, rd_byte_w} : '0;
		end
	end

	// ==========================================================
	// Voltage stepper: walks applied code one step per tick
	bscr_step_t state_q;
	bscr_step_t state_d;
	logic [BSCR_CODE_W-1:0] cur_q;
	logic [BSCR_CODE_W-1:0] cur_d;
	logic tick_w;
	logic differ_w;

	// A 25 mV step is one code step, so the walk moves by one
	assign differ_w = (cur_q != sel_code_w);

	bscr_step_timer u_step_timer (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(state_q == BSCR_ST_WAIT),
		.i_speed(regulator_config_q[BSCR_SPEED_LSB +: BSCR_SEL_W]),
		.o_tick(tick_w)
	);

	// Next state; a new target during a walk just redirects it
	always_comb begin
		state_d = state_q;
		cur_d = cur_q;
		case (state_q)
			BSCR_ST_IDLE: begin
				if (differ_w)
					state_d = BSCR_ST_WAIT;
			end
			BSCR_ST_WAIT: begin
				if (!differ_w)
					state_d = BSCR_ST_IDLE;
				else if (tick_w)
					state_d = BSCR_ST_STEP;
			end
			BSCR_ST_STEP: begin
				if (cur_q < sel_code_w)
					cur_d = cur_q + 1'b1;
				else if (cur_q > sel_code_w)
					cur_d = cur_q - 1'b1;
				state_d = BSCR_ST_WAIT;
			end
			default: state_d = BSCR_ST_IDLE;
		endcase
	end

	// Stepper registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= BSCR_ST_IDLE;
			cur_q <= '0;
		end else begin
			state_q <= state_d;
			cur_q <= cur_d;
		end
	end

	// ==========================================================
	// Decoded regulator outputs
	logic [1:0] freq_sel_w;
	logic [1:0] phase_sel_w;
	logic [12:0] freq_khz_w;

	assign freq_sel_w = regulator_config_q[BSCR_FREQ_LSB +: BSCR_SEL_W];
	assign phase_sel_w = regulator_config_q[BSCR_PHASE_LSB +: BSCR_SEL_W];
	assign freq_khz_w = (freq_sel_w == 2'b00) ? BSCR_FREQ0_KHZ :
		(freq_sel_w == 2'b01) ? BSCR_FREQ1_KHZ :
		(freq_sel_w == 2'b10) ? BSCR_FREQ2_KHZ : BSCR_FREQ_RSVD;

	// Outputs all registered
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_target_code <= '0;
			o_applied_code <= '0;
			o_applied_mv <= BSCR_MV_W'(BSCR_VMIN_MV);
			o_stepping <= 1'b0;
			o_reg_enable <= 1'b0;
			o_pfm_force <= 1'b0;
			o_switch_mode_field <= '0;
			o_current_limit_low_sel <= 1'b0;
			o_switch_freq_khz <= BSCR_FREQ0_KHZ;
			o_freq_reserved <= 1'b0;
			o_clock_phase_deg <= '0;
			o_voltage_step_speed_sel <= '0;
		end else begin
			o_target_code <= sel_code_w;
			o_applied_code <= cur_q;
			o_applied_mv <= code_to_mv(cur_q);
			o_stepping <= (state_q != BSCR_ST_IDLE);
			o_reg_enable <= !sleep_off_w;
			o_pfm_force <= (op_w == BSCR_OP_SLEEP) &&
				switching_mode_select_q[BSCR_KEEPALIVE_BIT];
			o_switch_mode_field <=
				switching_mode_select_q[BSCR_SWMODE_LSB +: BSCR_SWMODE_W];
			o_current_limit_low_sel <= regulator_config_q[BSCR_ILIM_BIT];
			o_switch_freq_khz <= freq_khz_w;
			o_freq_reserved <= (freq_sel_w == 2'b11);
			o_clock_phase_deg <= 9'(phase_sel_w) * BSCR_PHASE_STEP_DEG;
			o_voltage_step_speed_sel <=
				regulator_config_q[BSCR_SPEED_LSB +: BSCR_SEL_W];
		end
	end

endmodule : bscr_regs

// *** rtl/bscr_step_timer.sv ***
// Step-period timer for voltage stepping.
// Assumes one core clock; emits a one-cycle tick at the chosen period.
`timescale 1ns/100ps
module bscr_step_timer
	import bscr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [1:0] i_speed,
	output logic o_tick
);

	// ==========================================================
	// Period selection
	logic [BSCR_CNT_W-1:0] period_w;
	logic [BSCR_CNT_W-1:0] cnt_q;
	logic [BSCR_CNT_W-1:0] cnt_d;
	logic wrap_w;

	// Period per speed code
	assign period_w = (i_speed == 2'b00) ? BSCR_CNT_W'(BSCR_STEP0_CYC - 1) :
		(i_speed == 2'b01) ? BSCR_CNT_W'(BSCR_STEP1_CYC - 1) :
		(i_speed == 2'b10) ? BSCR_CNT_W'(BSCR_STEP2_CYC - 1) :
		BSCR_CNT_W'(BSCR_STEP3_CYC - 1);
	// Greater-or-equal so a speed change mid-count cannot overrun
	assign wrap_w = (cnt_q >= period_w);
	assign cnt_d = (!i_run || wrap_w) ? '0 : cnt_q + 1'b1;

	// ==========================================================
	// Counter and tick
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_tick <= i_run && wrap_w;
		end
	end

endmodule : bscr_step_timer

// *** sim/bscr_checker.sv ***
// Concurrent checks for the buck set point register bank.
// Assumes it is bound onto bscr_regs and sees only that module's ports.
`timescale 1ns/100ps
module bscr_checker
	import bscr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [BSCR_CODE_W-1:0] o_applied_code,
	input wire logic [BSCR_MV_W-1:0] o_applied_mv,
	input wire logic o_reg_enable,
	input wire logic o_pfm_force,
	input wire logic [12:0] o_switch_freq_khz,
	input wire logic o_freq_reserved,
	input wire logic [8:0] o_clock_phase_deg
);
	// Single domain, so one clock and one disable for all
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// ==========================================================
	// Bus answers
	AST_PREADY_ZERO_WAIT: assert property ((i_psel && !i_penable) ##1 i_penable |-> o_pready)
		else $error("no ready in first access cycle");
	AST_PREADY_IN_ACCESS: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside an access phase");
	AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
		else $error("error flag without ready");
	// Upper bits always zero, and the whole bus quiet outside answers
	AST_RDATA_QUIET: assert property (o_prdata[31:8] == 24'h0 && (o_pready || o_prdata == 32'h0))
		else $error("read data bits outside a byte answer");

	// ==========================================================
	// Regulator side
	AST_MV_CODING: assert property (o_applied_mv == 11'(BSCR_VMIN_MV + BSCR_VSTEP_MV * o_applied_code))
		else $error("millivolt output does not match code");
	AST_FREQ_RESERVED: assert property (o_freq_reserved |-> o_switch_freq_khz == 13'h0000)
		else $error("reserved frequency code gives a frequency");
	AST_PHASE_QUARTER: assert property (o_clock_phase_deg inside {9'h000, 9'h05a, 9'h0b4, 9'h10e})
		else $error("phase not a quarter turn");
	AST_PFM_KEEPS_ON: assert property (o_pfm_force |-> o_reg_enable)
		else $error("pulse-frequency mode while regulator off");
	// A step is one code, and the next cannot follow for many cycles
	AST_STEP_SINGLE: assert property ($changed(o_applied_code) |-> 6'(o_applied_code - $past(o_applied_code)) inside {6'h01, 6'h3f})
		else $error("applied code jumped more than one step");
	AST_STEP_HOLD: assert property ($changed(o_applied_code) |=> $stable(o_applied_code)[*8])
		else $error("applied code stepped too fast");

	// Main scenarios reached
	COV_SLVERR: cover property (o_pslverr);
	COV_STEP: cover property ($changed(o_applied_code));
	COV_PFM: cover property (o_pfm_force);
endmodule : bscr_checker

// *** sim/tb_top.sv ***
// Self-checking bench for the buck set point register bank.
// Assumes bscr_regs as the design top with bscr_checker bound onto it.
`timescale 1ns/100ps
module tb_top
	import bscr_pkg::*;
;
	// ==========================================================
	// Signals
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [BSCR_ADDR_W-1:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0;
	logic [3:0] i_pstrb = '0;
	logic i_mode_standby = 1'b0;
	logic i_mode_sleep = 1'b0;
	logic [31:0] o_prdata;
	logic o_pready, o_pslverr, o_stepping, o_reg_enable, o_pfm_force;
	logic o_current_limit_low_sel, o_freq_reserved;
	logic [5:0] o_target_code, o_applied_code;
	logic [10:0] o_applied_mv;
	logic [3:0] o_switch_mode_field;
	logic [12:0] o_switch_freq_khz;
	logic [8:0] o_clock_phase_deg;
	logic [1:0] o_voltage_step_speed_sel;
	logic [31:0] rd_q, err_q;
	int bad_count = 0;
	int checks_done = 0;

	// Core clock, 100 MHz
	always #5 i_clk = ~i_clk;

	bscr_regs uut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_mode_standby(i_mode_standby), .i_mode_sleep(i_mode_sleep),
		.o_target_code(o_target_code), .o_applied_code(o_applied_code),
		.o_applied_mv(o_applied_mv), .o_stepping(o_stepping), .o_reg_enable(o_reg_enable),
		.o_pfm_force(o_pfm_force), .o_switch_mode_field(o_switch_mode_field),
		.o_current_limit_low_sel(o_current_limit_low_sel),
		.o_switch_freq_khz(o_switch_freq_khz), .o_freq_reserved(o_freq_reserved),
		.o_clock_phase_deg(o_clock_phase_deg),
		.o_voltage_step_speed_sel(o_voltage_step_speed_sel)
	);

	// ==========================================================
	// Shared tasks
	task automatic wrap_up();
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// One transfer; held until ready is seen at an edge, bounded
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		i_pstrb <= s;
		@(posedge i_clk);
		i_penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge i_clk);
			if (o_pready === 1'b1) break;
		end
		if (n == 16) begin
			bad_count++;
			wrap_up();
		end
		rd_q = o_prdata;
		err_q = 32'(o_pslverr);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, {idx, 2'b00}, d, 4'hf);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] e);
		apb(1'b0, {idx, 2'b00}, 32'h0000_0000, 4'h0);
		cmp(rd_q, exp);
		cmp(err_q, e);
	endtask : rd

	// Registered outputs need two edges to show a change
	task automatic settle();
		repeat (2) @(posedge i_clk);
	endtask : settle

	// ==========================================================
	// Scenarios
	task automatic t_reset_vals();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(BSCR_IDX_NORMAL + 8'(i), 32'h0000_0000, 32'h0000_0000);
		end
		// Own status word: normal mode, idle, regulator on; writes ignored
		wr(BSCR_IDX_STATUS, 32'hffff_ffff);
		cmp(err_q, 32'h0000_0000);
		rd(BSCR_IDX_STATUS, 32'h0000_0008, 32'h0000_0000);
		cmp(o_applied_mv, 32'h0000_012c);
		cmp(o_switch_freq_khz, 32'h0000_03e8);
	endtask : t_reset_vals

	// Each speed code: time of first step, then walk to target
	task automatic t_step_speed();
		int p;
		int n;
		logic [5:0] c0;
		logic [5:0] tgt;
		for (int s = 0; s < 4; s++) begin
			p = BSCR_STEP0_CYC << s;
			tgt = 6'(13 + s);
			wr(BSCR_IDX_CONF, 32'(s << 6));
			wr(BSCR_IDX_NORMAL, 32'(tgt));
			c0 = o_applied_code;
			for (n = 0; n < p + 16; n++) begin
				@(posedge i_clk);
				if (o_applied_code !== c0) break;
			end
			if (n == p + 16) begin
				bad_count++;
				wrap_up();
			end
			cmp(32'(n >= p && n <= p + 8), 32'h0000_0001);
			// Walk still flagged busy when the first step shows
			cmp(o_stepping, 32'h0000_0001);
			for (n = 0; n < 14 * (p + 16) && o_applied_code !== tgt; n++) begin
				@(posedge i_clk);
			end
			if (o_applied_code !== tgt) begin
				bad_count++;
				wrap_up();
			end
			cmp(o_applied_code, 32'(tgt));
			cmp(o_applied_mv, 32'(300 + 25 * tgt));
			// Busy flag drops once the target is reached
			settle();
			cmp(o_stepping, 32'h0000_0000);
		end
	endtask : t_step_speed

	task automatic t_conf_decode();
		logic [12:0] ftab [4];
		ftab = '{13'h03e8, 13'h07d0, 13'h0fa0, 13'h0000};
		for (int c = 0; c < 4; c++) begin
			wr(BSCR_IDX_CONF, 32'({c[1:0], c[1:0], c[1:0], 1'b0, c[0]}));
			settle();
			cmp(o_switch_freq_khz, 32'(ftab[c]));
			cmp(o_freq_reserved, 32'(c == 3));
			cmp(o_clock_phase_deg, 32'(c * 90));
			cmp(o_voltage_step_speed_sel, 32'(c[1:0]));
			cmp(o_current_limit_low_sel, 32'(c[0]));
		end
	endtask : t_conf_decode

	// Mode inputs pick the set point; sleep behaviour from keepalive bit
	task automatic t_mode_select();
		wr(BSCR_IDX_NORMAL, 32'h0000_0014);
		wr(BSCR_IDX_STANDBY, 32'h0000_001e);
		wr(BSCR_IDX_SLEEP, 32'h0000_0028);
		for (int m = 0; m < 4; m++) begin
			@(posedge i_clk);
			i_mode_standby <= m[0];
			i_mode_sleep <= m[1];
			settle();
			cmp(o_target_code, m[1] ? 32'h0000_0028 : (m[0] ? 32'h0000_001e : 32'h0000_0014));
		end
		wr(BSCR_IDX_MODE, 32'h0000_0005);
		settle();
		cmp(o_switch_mode_field, 32'h0000_0005);
		cmp({o_reg_enable, o_pfm_force}, 32'h0000_0000);
		wr(BSCR_IDX_MODE, 32'h0000_0025);
		settle();
		cmp({o_reg_enable, o_pfm_force}, 32'h0000_0003);
		@(posedge i_clk);
		i_mode_standby <= 1'b0;
		i_mode_sleep <= 1'b0;
		settle();
		cmp({o_reg_enable, o_pfm_force}, 32'h0000_0002);
	endtask : t_mode_select

	// Unused bits, missing strobe, unmapped and unaligned places
	task automatic t_masks();
		logic [7:0] msk [5];
		msk = '{8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hfd};
		for (int i = 0; i < 5; i++) begin
			wr(BSCR_IDX_NORMAL + 8'(i), 32'hffff_ffff);
			rd(BSCR_IDX_NORMAL + 8'(i), 32'(msk[i]), 32'h0000_0000);
			apb(1'b1, {BSCR_IDX_NORMAL + 8'(i), 2'b00}, 32'h0000_0000, 4'h0);
			rd(BSCR_IDX_NORMAL + 8'(i), 32'(msk[i]), 32'h0000_0000);
		end
		wr(8'h26, 32'hffff_ffff);
		cmp(err_q, 32'h0000_0001);
		rd(8'h26, 32'h0000_0000, 32'h0000_0001);
		apb(1'b0, 10'h081, 32'h0000_0000, 4'h0);
		cmp({rd_q[30:0], err_q[0]}, 32'h0000_0001);
	endtask : t_masks

	// ==========================================================
	// Main sequence, ending with a second reset in mid-run
	initial begin
		t_reset_vals();
		t_step_speed();
		t_conf_decode();
		t_mode_select();
		t_masks();
		t_reset_vals();
		wrap_up();
	end
endmodule : tb_top

bind bscr_regs bscr_checker chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
	.i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_applied_code(o_applied_code), .o_applied_mv(o_applied_mv), .o_reg_enable(o_reg_enable),
	.o_pfm_force(o_pfm_force), .o_switch_freq_khz(o_switch_freq_khz),
	.o_freq_reserved(o_freq_reserved), .o_clock_phase_deg(o_clock_phase_deg));
